// >>> rtl/spcc_top.sv
/*
  Serial peripheral port with its control and configuration registers,
  a master and slave byte shifter and an AXI4-Lite register slave.
  Assumes pins arrive asynchronously and pass the synchroniser first.
*/
module spcc_top #(
  parameter int HALF_BASE = 2
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // AXI4-Lite write address
  input wire logic [spcc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [spcc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Serial clock pin
  input wire logic SCLK_I,
  output logic SCLK_O,
  output logic SCLK_OE_N,
  // Controller-out data pin
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE_N,
  // Controller-in data pin
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE_N,
  // Select pin
  input wire logic SS_I,
  output logic SS_O,
  output logic SS_OE_N,
  // Interrupt
  output logic IRQ
);
  typedef enum logic [1:0] {ENG_IDLE, ENG_SHIFT, ENG_GAP} spcc_eng_t;

  ////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] ctrl_reg;
  logic [7:0] gap_reg;
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic page_reg;
  logic [7:0] rx_buf_reg;

  // Control fields
  logic drive_en, port_on, lsb_first, role_ctrl, idle_lvl, phase, fault_off;
  logic [1:0] rate_sel, gap_sel;
  assign drive_en = ctrl_reg[spcc_pkg::CTL_DRIVE_EN];
  assign port_on = ctrl_reg[spcc_pkg::CTL_ON];
  assign lsb_first = ctrl_reg[spcc_pkg::CTL_LSB_FIRST];
  assign role_ctrl = ctrl_reg[spcc_pkg::CTL_ROLE];
  assign idle_lvl = ctrl_reg[spcc_pkg::CTL_IDLE_LVL];
  assign phase = ctrl_reg[spcc_pkg::CTL_PHASE];
  assign rate_sel = {ctrl_reg[spcc_pkg::CTL_RATE_HI], ctrl_reg[spcc_pkg::CTL_RATE_LO]};
  assign gap_sel = gap_reg[spcc_pkg::GAP_SEL_HI:spcc_pkg::GAP_SEL_LO];
  assign fault_off = status_reg[spcc_pkg::ST_FAULT_OFF];

  logic master_mode, slave_mode;
  assign master_mode = port_on && role_ctrl;
  assign slave_mode = port_on && !role_ctrl;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  logic [spcc_pkg::ADDR_W-1:0] aw_addr_reg;
  logic aw_full_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_go;
  logic [9:0] wr_idx;

  assign S_AXI_AWREADY = !aw_full_reg;
  assign S_AXI_WREADY = !w_full_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_idx = aw_addr_reg[spcc_pkg::ADDR_W-1:2];

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (S_AXI_AWVALID && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      w_full_reg <= 1'b0;
      w_data_reg <= spcc_pkg::RST_BYTE;
      w_lane_reg <= 1'b0;
    end else if (S_AXI_WVALID && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA[7:0];
      w_lane_reg <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_full_reg <= 1'b0;
    end
  end

  // Write decode; page picks which register sits at the shared index
  logic wr_main, wr_gap, wr_status, wr_data, wr_page, wr_mask, wr_mapped;
  always_comb begin
    wr_main = 1'b0;
    wr_gap = 1'b0;
    wr_status = 1'b0;
    wr_data = 1'b0;
    wr_page = 1'b0;
    wr_mask = 1'b0;
    wr_mapped = 1'b1;
    unique case (wr_idx)
      spcc_pkg::IDX_MAIN_CTRL: begin
        wr_main = wr_go && w_lane_reg && !page_reg;
        wr_gap = wr_go && w_lane_reg && page_reg;
      end
      spcc_pkg::IDX_STATUS: wr_status = wr_go && w_lane_reg;
      spcc_pkg::IDX_DATA: wr_data = wr_go && w_lane_reg;
      spcc_pkg::IDX_PAGE: wr_page = wr_go && w_lane_reg;
      spcc_pkg::IDX_IRQ_MASK: wr_mask = wr_go && w_lane_reg;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= spcc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? spcc_pkg::RESP_OKAY : spcc_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic rvalid_reg;
  logic [7:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rd_byte;
  logic rd_mapped;

  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = {24'h000000, rdata_reg};
  assign S_AXI_RRESP = rresp_reg;

  always_comb begin
    rd_byte = spcc_pkg::RST_BYTE;
    rd_mapped = 1'b1;
    unique case (S_AXI_ARADDR[spcc_pkg::ADDR_W-1:2])
      spcc_pkg::IDX_MAIN_CTRL: rd_byte = page_reg ? (gap_reg & spcc_pkg::GAP_RW_MASK) : ctrl_reg;
      spcc_pkg::IDX_STATUS: rd_byte = status_reg;
      spcc_pkg::IDX_DATA: rd_byte = rx_buf_reg;
      spcc_pkg::IDX_PAGE: rd_byte = {7'h00, page_reg};
      spcc_pkg::IDX_IRQ_MASK: rd_byte = mask_reg;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= spcc_pkg::RST_BYTE;
      rresp_reg <= spcc_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_byte;
      rresp_reg <= rd_mapped ? spcc_pkg::RESP_OKAY : spcc_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= spcc_pkg::RST_BYTE;
      gap_reg <= spcc_pkg::RST_BYTE;
      page_reg <= 1'b0;
      mask_reg <= spcc_pkg::RST_BYTE;
    end else begin
      if (wr_main) ctrl_reg <= w_data_reg;
      if (wr_gap) gap_reg <= w_data_reg & spcc_pkg::GAP_RW_MASK;
      if (wr_page) page_reg <= w_data_reg[0];
      if (wr_mask) mask_reg <= w_data_reg & spcc_pkg::ST_EVENT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and link clock edge detection
  logic [3:0] pins_s;
  logic sclk_s, mosi_s, miso_s, ss_s, sclk_prev_reg;
  spcc_sync #(.WIDTH(4)) u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .async_in({SCLK_I, MOSI_I, MISO_I, SS_I}),
    .sync_out(pins_s)
  );
  assign {sclk_s, mosi_s, miso_s, ss_s} = pins_s;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) sclk_prev_reg <= 1'b0;
    else sclk_prev_reg <= sclk_s;
  end

  ////////////////////////////////////////////////////////////////////
  // Byte engine
  spcc_eng_t state_reg;
  logic [4:0] edge_cnt_reg;
  logic [2:0] gap_cnt_reg;
  logic [7:0] tx_sr_reg, rx_sr_reg;
  logic out_reg, sclk_lvl_reg, ss_lvl_reg;
  logic half_tick, slave_sel, fault_evt, edge_evt, drive_edge, sample_edge, last_edge;
  logic start, load_ok, collision, in_bit;
  logic [7:0] rx_shifted;
  logic [2:0] gap_halves;

  spcc_sclk_gen #(.HALF_BASE(HALF_BASE)) u_sclk_gen (
    .clk(CLOCK),
    .rst_n(RST_N),
    .run(master_mode && state_reg != ENG_IDLE),
    .rate_sel(rate_sel),
    .half_tick(half_tick)
  );

  assign slave_sel = slave_mode && !ss_s;
  assign fault_evt = master_mode && !fault_off && !ss_s;
  assign edge_evt = state_reg == ENG_SHIFT && (master_mode ? half_tick : (slave_sel && sclk_s != sclk_prev_reg));
  assign drive_edge = edge_evt && (edge_cnt_reg[0] != phase);
  assign sample_edge = edge_evt && (edge_cnt_reg[0] == phase);
  assign last_edge = edge_evt && edge_cnt_reg == spcc_pkg::EDGES_PER_BYTE - 5'h01;
  assign in_bit = master_mode ? miso_s : mosi_s;
  assign rx_shifted = lsb_first ? {in_bit, rx_sr_reg[7:1]} : {rx_sr_reg[6:0], in_bit};
  assign gap_halves = {1'b0, gap_sel} + (phase ? spcc_pkg::GAP_HALVES_PH1 : spcc_pkg::GAP_HALVES_PH0);
  assign collision = wr_data && port_on && (state_reg != ENG_IDLE || slave_sel);
  assign load_ok = wr_data && port_on && !collision && !status_reg[spcc_pkg::ST_DONE];
  assign start = load_ok && master_mode && !fault_evt;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ENG_IDLE;
      edge_cnt_reg <= 5'h00;
      gap_cnt_reg <= 3'h0;
    end else if (!port_on || fault_evt) begin
      state_reg <= ENG_IDLE;
      edge_cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        ENG_IDLE: begin
          edge_cnt_reg <= 5'h00;
          if (start || slave_sel) state_reg <= ENG_SHIFT;
        end
        ENG_SHIFT: begin
          if (slave_mode && !slave_sel) begin
            state_reg <= ENG_IDLE;
          end else if (last_edge) begin
            state_reg <= master_mode ? ENG_GAP : ENG_IDLE;
            gap_cnt_reg <= gap_halves;
          end else if (edge_evt) begin
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
          end
        end
        ENG_GAP: begin
          if (half_tick) begin
            gap_cnt_reg <= gap_cnt_reg - 3'h1;
            if (gap_cnt_reg == 3'h1) state_reg <= ENG_IDLE;
          end
        end
      endcase
    end
  end

  // Shift registers and data line
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tx_sr_reg <= spcc_pkg::RST_BYTE;
      rx_sr_reg <= spcc_pkg::RST_BYTE;
      out_reg <= 1'b0;
    end else begin
      if (load_ok) tx_sr_reg <= w_data_reg;
      if (state_reg == ENG_IDLE && (start || slave_sel) && !phase) begin
        // Phase zero puts the first bit out before the first edge
        out_reg <= lsb_first ? tx_sr_reg[0] : tx_sr_reg[7];
        if (start) out_reg <= lsb_first ? w_data_reg[0] : w_data_reg[7];
        tx_sr_reg <= lsb_first ? {1'b0, tx_sr_reg[7:1]} : {tx_sr_reg[6:0], 1'b0};
        if (start) tx_sr_reg <= lsb_first ? {1'b0, w_data_reg[7:1]} : {w_data_reg[6:0], 1'b0};
      end else if (drive_edge) begin
        out_reg <= lsb_first ? tx_sr_reg[0] : tx_sr_reg[7];
        tx_sr_reg <= lsb_first ? {1'b0, tx_sr_reg[7:1]} : {tx_sr_reg[6:0], 1'b0};
      end
      if (sample_edge) rx_sr_reg <= rx_shifted;
    end
  end

  // Serial clock and select levels in master role
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_lvl_reg <= 1'b0;
      ss_lvl_reg <= 1'b1;
    end else begin
      if (master_mode && state_reg == ENG_SHIFT) begin
        if (edge_evt) sclk_lvl_reg <= !sclk_lvl_reg;
      end else begin
        sclk_lvl_reg <= idle_lvl;
      end
      ss_lvl_reg <= !(master_mode && state_reg == ENG_SHIFT && !fault_evt);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive buffer, status and interrupt
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) rx_buf_reg <= spcc_pkg::RST_BYTE;
    else if (last_edge) rx_buf_reg <= sample_edge ? rx_shifted : rx_sr_reg;
  end

  logic [7:0] ev_set;
  always_comb begin
    ev_set = spcc_pkg::RST_BYTE;
    ev_set[spcc_pkg::ST_DONE] = last_edge;
    ev_set[spcc_pkg::ST_COLLISION] = collision;
    ev_set[spcc_pkg::ST_OVERRUN] = last_edge && status_reg[spcc_pkg::ST_DONE];
    ev_set[spcc_pkg::ST_FAULT] = fault_evt;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      status_reg <= spcc_pkg::RST_BYTE;
    end else begin
      status_reg <= ((status_reg & ~(wr_status ? w_data_reg & spcc_pkg::ST_EVENT_MASK : 8'h00)) | ev_set)
                    & spcc_pkg::ST_EVENT_MASK
                    | ((wr_status ? w_data_reg : status_reg) & spcc_pkg::ST_RW_MASK);
    end
  end

  assign IRQ = |(status_reg & mask_reg & spcc_pkg::ST_EVENT_MASK);

  ////////////////////////////////////////////////////////////////////
  // Pin drive
  assign SCLK_O = sclk_lvl_reg;
  assign SCLK_OE_N = !master_mode;
  assign MOSI_O = out_reg;
  assign MOSI_OE_N = !master_mode;
  assign MISO_O = out_reg;
  assign MISO_OE_N = !slave_sel;
  assign SS_O = ss_lvl_reg;
  assign SS_OE_N = !(master_mode && fault_off && drive_en);
endmodule

// >>> include/spcc_pkg.sv
/*
  Constants shared by the serial port control block: register indices,
  field positions, reset values and bus answers.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package spcc_pkg;
  // Register indices; the byte address is four times the index
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_MAIN_CTRL = 10'h0F3;
  localparam logic [9:0] IDX_STATUS = 10'h0F4;
  localparam logic [9:0] IDX_DATA = 10'h0F5;
  localparam logic [9:0] IDX_PAGE = 10'h100;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h101;
  ////////////////////////////////////////////////////////////////////
  // Main control fields
  localparam int CTL_DRIVE_EN = 7;
  localparam int CTL_ON = 6;
  localparam int CTL_LSB_FIRST = 5;
  localparam int CTL_ROLE = 4;
  localparam int CTL_IDLE_LVL = 3;
  localparam int CTL_PHASE = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  // Byte gap control fields
  localparam int GAP_SEL_HI = 1;
  localparam int GAP_SEL_LO = 0;
  // Status fields; the top four are sticky events
  localparam int ST_DONE = 7;
  localparam int ST_COLLISION = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FAULT = 4;
  localparam int ST_FAULT_OFF = 3;
  localparam logic [7:0] ST_EVENT_MASK = 8'hF0;
  localparam logic [7:0] ST_RW_MASK = 8'h08;
  localparam logic [7:0] GAP_RW_MASK = 8'h03;
  ////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Link timing, in half serial clock periods
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam logic [2:0] GAP_HALVES_PH0 = 3'h1;
  localparam logic [2:0] GAP_HALVES_PH1 = 3'h2;
  // AXI answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/spcc_sync.sv
/*
  Two flip-flop synchroniser for pin inputs.
  Assumes each bit is an independent level from outside the clock domain.
*/
module spcc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule

// >>> rtl/spcc_sclk_gen.sv
/*
  Half-period tick generator for the master serial clock.
  Assumes run is held for a whole transfer; the count restarts when run drops.
*/
module spcc_sclk_gen #(
  parameter int HALF_BASE = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [1:0] rate_sel,
  // Tick
  output logic half_tick
);
  logic [7:0] cnt_reg;
  logic [7:0] half_len;

  // Each rate step doubles the half period
  assign half_len = 8'(HALF_BASE << rate_sel);
  assign half_tick = run && (cnt_reg == half_len - 8'h01);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else if (!run || half_tick) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// >>> sim/spcc_top_props.sv
/*
  Checker for the serial port top: bus answers, pin roles, byte framing.
  Assumes it is bound to every spcc_top instance.
*/
module spcc_top_props #(
  parameter int HALF_BASE = 2
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Pins
  input wire logic SCLK_OE_N,
  input wire logic MOSI_OE_N,
  input wire logic MISO_OE_N,
  input wire logic SS_O,
  input wire logic SS_OE_N,
  input wire logic IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Cycles the select line has stood high, saturating
  logic [7:0] hi_cnt;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) hi_cnt <= 8'hFF;
    else if (!SS_O) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////
  chk_pin_pair: assert property (MOSI_OE_N == SCLK_OE_N)
    else $error("clock and data drive differ");
  chk_no_miso: assert property (!SCLK_OE_N |-> MISO_OE_N)
    else $error("master drives its input line");
  chk_sel_gate: assert property (SCLK_OE_N |-> SS_OE_N)
    else $error("select driven outside master");
  chk_byte_hold: assert property ($fell(SS_O) |=> !SS_O [*8])
    else $error("select released too early");
  chk_gap_min: assert property ($fell(SS_O) |-> hi_cnt >= 8'(HALF_BASE))
    else $error("gap between bytes too short");
  chk_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
    else $error("write not answered");
  chk_b_stand: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  chk_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h0)
    else $error("read answer late or wide");
  chk_r_stand: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  cover property ($fell(SS_O) && !SS_OE_N);
  cover property ($rose(IRQ));
  cover property (S_AXI_BVALID && S_AXI_BRESP == spcc_pkg::RESP_SLVERR);
endmodule
bind spcc_top spcc_top_props #(.HALF_BASE(HALF_BASE)) u_props (
  .CLOCK(CLOCK), .RST_N(RST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .SCLK_OE_N(SCLK_OE_N), .MOSI_OE_N(MOSI_OE_N), .MISO_OE_N(MISO_OE_N),
  .SS_O(SS_O), .SS_OE_N(SS_OE_N), .IRQ(IRQ)
);

// >>> sim/spcc_peer_model.sv
/*
  Behavioural serial peripheral on the far side of the port.
  Assumes the bench hands it the frame format set in the port.
*/
module spcc_peer_model (
  // Link pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  // Frame format
  input wire logic idle_lvl,
  input wire logic phase,
  input wire logic lsb_first,
  // Data
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  initial miso = 1'h1;
  initial rx_byte = 8'h00;
  function automatic int bit_at(input int i);
    return lsb_first ? i : 7 - i;
  endfunction
  always @(negedge ss_n) begin
    n = 0;
    if (!phase) miso = tx_byte[bit_at(0)];
  end
  // Released line shows the inverse of its last level
  always @(posedge ss_n) miso = ~miso;
  // Leading edge leaves the idle level; phase picks the sampling edge
  always @(sclk) begin
    if (!ss_n) begin
      if ((sclk != idle_lvl) ^ phase) begin
        rx_byte[bit_at(n)] = mosi;
        n++;
      end else if (n < 8 && (phase || n > 0)) begin
        miso = tx_byte[bit_at(n)];
      end
    end
  end
endmodule

// >>> sim/tb_spcc_top.sv
/*
  Bench for the serial port top: registers, master bytes in every format,
  faults, masking and a slave byte.
  Assumes the checker and peer model are compiled before it.
*/
module tb_spcc_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_MAIN = {spcc_pkg::IDX_MAIN_CTRL, 2'h0};
  localparam logic [11:0] A_ST = {spcc_pkg::IDX_STATUS, 2'h0};
  localparam logic [11:0] A_DATA = {spcc_pkg::IDX_DATA, 2'h0};
  localparam logic [11:0] A_PAGE = {spcc_pkg::IDX_PAGE, 2'h0};
  localparam logic [11:0] A_MASK = {spcc_pkg::IDX_IRQ_MASK, 2'h0};
  localparam logic [1:0] OK = spcc_pkg::RESP_OKAY;
  int fail_count = 0;
  int num_checks = 0;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, peer_miso;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_o, ss_oe_n;
  logic sclk_tb = 1'h0, mosi_tb = 1'h0, ss_ext = 1'h1, sclk_idle_level = 1'h0, sclk_sample_phase = 1'h0, lsb = 1'h0;
  logic [7:0] ptx = 8'h00;
  logic [7:0] prx;
  // Pin levels; select has a pull-up
  wire logic sclk_w = sclk_oe_n ? sclk_tb : sclk_o;
  wire logic mosi_w = mosi_oe_n ? mosi_tb : mosi_o;
  wire logic miso_w = miso_oe_n ? peer_miso : miso_o;
  wire logic ss_w = ss_oe_n ? ss_ext : ss_o;
  spcc_top #(.HALF_BASE(2)) dut (
    .CLOCK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SCLK_I(sclk_w), .SCLK_O(sclk_o), .SCLK_OE_N(sclk_oe_n),
    .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_N(mosi_oe_n),
    .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_N(miso_oe_n),
    .SS_I(ss_w), .SS_O(ss_o), .SS_OE_N(ss_oe_n), .IRQ(irq)
  );
  spcc_peer_model peer (
    .sclk(sclk_w), .mosi(mosi_w), .ss_n(ss_w), .idle_lvl(sclk_idle_level), .phase(sclk_sample_phase),
    .lsb_first(lsb), .tx_byte(ptx), .miso(peer_miso), .rx_byte(prx)
  );
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) awvalid <= 1'h0;
      if (w && wready) wvalid <= 1'h0;
      aw = aw && !awready;
      w = w && !wready;
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'h0;
    chk({6'h0, bresp}, {6'h0, er}, "bresp");
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge clk);
    rready <= 1'h0;
    d = rdata[7:0];
    r = rresp;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp, what);
    chk({6'h0, r}, {6'h0, OK}, "rresp");
  endtask
  task automatic wait_done;
    logic [7:0] v;
    logic [1:0] r;
    do rd(A_ST, v, r); while (!v[7]);
  endtask
  // One master byte in the format given by the control byte
  task automatic mx(input logic [7:0] c, input logic [7:0] d);
    sclk_idle_level <= c[3];
    sclk_sample_phase <= c[2];
    lsb <= c[5];
    ptx <= ~d;
    wr(A_MAIN, c, OK);
    wr(A_DATA, d, OK);
    wait_done();
    chk(prx, d, "sent");
    chk(8'(irq), 8'h01, "irq");
    rdc(A_DATA, ~d, "rcvd");
    chk(8'(sclk_o), 8'(c[3]), "idle");
    wr(A_ST, 8'h88, OK);
    chk(8'(irq), 8'h00, "irq off");
  endtask
  task automatic slave_byte(input logic [7:0] b);
    ss_ext <= 1'h0;
    for (int i = 7; i >= 0; i--) begin
      mosi_tb <= b[i];
      #80 sclk_tb <= 1'h1;
      #80 sclk_tb <= 1'h0;
    end
    #80 ss_ext <= 1'h1;
    mosi_tb <= ~b[0];
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    $display("BAD %0t watchdog", $time);
    close_out();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [1:0] r;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    rdc(A_MAIN, 8'h00, "main");
    rdc(A_ST, 8'h00, "status");
    wr(A_PAGE, 8'h01, OK);
    rdc(A_MAIN, 8'h00, "gap");
    wr(A_MAIN, 8'hFF, OK);
    rdc(A_MAIN, 8'h03, "gap bits");
    wr(A_PAGE, 8'h00, OK);
    rdc(A_MAIN, 8'h00, "page");
    wr(12'h000, 8'h55, spcc_pkg::RESP_SLVERR);
    rd(12'h000, v, r);
    chk({6'h0, r}, {6'h0, spcc_pkg::RESP_SLVERR}, "unmapped");
    wr(A_MASK, 8'h80, OK);
    wr(A_ST, 8'h08, OK);
    for (int i = 0; i < 8; i++) begin
      wr(A_PAGE, 8'h01, OK);
      wr(A_MAIN, 8'(i), OK);
      wr(A_PAGE, 8'h00, OK);
      mx({2'h3, i[0], 1'h1, i[1], i[2], 2'h1}, 8'hA6 ^ 8'(i * 37));
    end
    wr(A_MASK, 8'h00, OK);
    // Data written inside the longest gap is refused
    wr(A_DATA, 8'h3C, OK);
    rdc(A_ST, 8'h48, "gap busy");
    wr(A_DATA, 8'h3C, OK);
    wr(A_DATA, 8'hC3, OK);
    wait_done();
    chk(8'(irq), 8'h00, "masked");
    rdc(A_ST, 8'hC8, "collision");
    wr(A_MASK, 8'h40, OK);
    chk(8'(irq), 8'h01, "unmasked");
    wr(A_ST, 8'hC8, OK);
    chk(8'(irq), 8'h00, "cleared");
    wr(A_MAIN, 8'h51, OK);
    chk(8'(ss_oe_n), 8'h01, "select off");
    wr(A_ST, 8'h00, OK);
    wr(A_MAIN, 8'hD0, OK);
    chk(8'(ss_oe_n), 8'h01, "select input");
    ss_ext <= 1'h0;
    repeat (4) @(posedge clk);
    ss_ext <= 1'h1;
    rdc(A_ST, 8'h10, "role fault");
    wr(A_ST, 8'h18, OK);
    rdc(A_ST, 8'h08, "fault clear");
    wr(A_MAIN, 8'h91, OK);
    chk(8'(sclk_oe_n), 8'h01, "off drive");
    wr(A_DATA, 8'h3C, OK);
    repeat (40) @(posedge clk);
    chk(8'(ss_o), 8'h01, "off select");
    rdc(A_ST, 8'h08, "off done");
    wr(A_MAIN, 8'h40, OK);
    chk(8'(sclk_oe_n), 8'h01, "slave clock");
    slave_byte(8'h5A);
    rdc(A_DATA, 8'h5A, "slave rx");
    rdc(A_ST, 8'h88, "slave done");
    close_out();
  end
endmodule
